// File: include/brf_defs.svh
// constants for the banked cpu register file
`ifndef BRF_DEFS_SVH
`define BRF_DEFS_SVH

// status word fields
`define BRF_SW_MODE_BIT 30
`define BRF_SW_BANK_BIT 29
`define BRF_SW_BLOCK_BIT 28
`define BRF_SW_IMASK_HI 7
`define BRF_SW_IMASK_LO 4
`define BRF_SW_RESET 32'h700000F0
`define BRF_SW_PRIV_MASK 32'h700003F3
`define BRF_SW_USER_MASK 32'h00000303

// other reset values
`define BRF_PC_RESET 32'hA0000000
`define BRF_VBR_RESET 32'h00000000

// avalon byte offsets
`define BRF_OFS_STATUS 8'h00
`define BRF_OFS_VBR 8'h04
`define BRF_OFS_PC 8'h08
`define BRF_OFS_FAULTS 8'h0C

`endif

// File: include/brf_pkg.sv
// types for the banked cpu register file
package brf_pkg;

  typedef enum logic [3:0] {
    BRF_CTL_STATUS = 4'h0,
    BRF_CTL_GBASE = 4'h1,
    BRF_CTL_SSTATUS = 4'h2,
    BRF_CTL_SPC = 4'h3,
    BRF_CTL_VBASE = 4'h4,
    BRF_CTL_MULTIPLY_ACCUMULATE_HIGH = 4'h5,
    BRF_CTL_MULTIPLY_ACCUMULATE_LOW = 4'h6,
    BRF_CTL_LINK = 4'h7,
    BRF_CTL_PC = 4'h8
  } brf_ctl_t;

  typedef enum logic [1:0] {
    BRF_AV_IDLE = 2'b00,
    BRF_AV_DONE = 2'b01
  } brf_av_t;

endpackage

// File: verilog/brf_register_file.sv
// banked general/control/system register file with mode permission logic
`timescale 1ns/1ns
`include "brf_defs.svh"

module brf_register_file
  import brf_pkg::*;
#(
  parameter int DW = 32
) (
  // clock, reset, enable
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clkEn,
  // general register ports
  input wire logic [3:0] rdIdxA,
  input wire logic [3:0] rdIdxB,
  output logic [DW-1:0] rdDataA,
  output logic [DW-1:0] rdDataB,
  input wire logic gprWe,
  input wire logic [3:0] gprWrIdx,
  input wire logic [DW-1:0] gprWrData,
  // other-bank access by control load/store
  input wire logic altRe,
  input wire logic altWe,
  input wire logic [2:0] altIdx,
  input wire logic [DW-1:0] altWrData,
  output logic [DW-1:0] altRdData,
  // control and system register access
  input wire logic ctlRe,
  input wire logic ctlWe,
  input wire brf_ctl_t ctlSel,
  input wire logic [DW-1:0] ctlWrData,
  output logic [DW-1:0] ctlRdData,
  output logic accessFault,
  // exception entry and return
  input wire logic excTake,
  input wire logic excReturn,
  input wire logic pcWe,
  input wire logic [DW-1:0] pcNext,
  // state view
  output logic [DW-1:0] statusWord,
  output logic [DW-1:0] progCounter,
  output logic privMode,
  // avalon-mm slave
  input wire logic [7:0] avAddress,
  input wire logic avRead,
  input wire logic avWrite,
  input wire logic [31:0] avWriteData,
  output logic [31:0] avReadData,
  output logic avWaitRequest
);

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  logic [DW-1:0] bank0Q [8];
  logic [DW-1:0] bank1Q [8];
  logic [DW-1:0] highQ [8];
  logic [DW-1:0] statusQ, ssrQ, spcQ, gbrQ, vbrQ;
  logic [DW-1:0] machQ, maclQ, linkQ, pcQ;
  logic [DW-1:0] rdDataAQ, rdDataBQ, altRdQ, ctlRdQ;
  logic faultQ;
  logic [15:0] faultCntQ;
  logic mode, bankSel, useBank1, ctlOk, altOk, avAckQ, avSwWr;
  brf_av_t avStateQ;

  // mode bit alone picks user or privileged
  // mode from status
  assign mode = statusQ[`BRF_SW_MODE_BIT];
  assign bankSel = statusQ[`BRF_SW_BANK_BIT];
  assign useBank1 = mode & bankSel;
  assign altOk = mode;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // sixteen: low eight from one of two banks, high eight unbanked
  function automatic logic [DW-1:0] gprRead(input logic [3:0] idx);
    if (idx[3]) begin
      gprRead = highQ[idx[2:0]];
    end else if (useBank1) begin
      gprRead = bank1Q[idx[2:0]];
    end else begin
      gprRead = bank0Q[idx[2:0]];
    end
  endfunction

  function automatic logic ctlAllowed(input brf_ctl_t sel, input logic md);
    case (sel)
      BRF_CTL_SSTATUS, BRF_CTL_SPC, BRF_CTL_VBASE: ctlAllowed = md;
      BRF_CTL_STATUS, BRF_CTL_GBASE, BRF_CTL_MULTIPLY_ACCUMULATE_HIGH, BRF_CTL_MULTIPLY_ACCUMULATE_LOW,
      BRF_CTL_LINK, BRF_CTL_PC: ctlAllowed = 1'b1;
      default: ctlAllowed = 1'b0;
    endcase
  endfunction

  // keeps protected status bits unless privileged
  function automatic logic [DW-1:0] swMerge(input logic [DW-1:0] old,
                                            input logic [DW-1:0] wr,
                                            input logic md);
    logic [DW-1:0] m;
    m = md ? `BRF_SW_PRIV_MASK : `BRF_SW_USER_MASK;
    swMerge = (old & ~m) | (wr & m);
  endfunction

  assign ctlOk = ctlAllowed(ctlSel, mode);

  // ----------------------------------------------------------------
  // general registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (clkEn) begin
      if (gprWe && gprWrIdx[3]) begin
        highQ[gprWrIdx[2:0]] <= gprWrData;
      end else if (gprWe && useBank1) begin
        bank1Q[gprWrIdx[2:0]] <= gprWrData;
      end else if (gprWe) begin
        bank0Q[gprWrIdx[2:0]] <= gprWrData;
      end
      // other bank by control ops
      // alt port never targets the bank the gpr port writes
      if (altWe && altOk) begin
        if (bankSel) begin
          bank0Q[altIdx] <= altWrData;
        end else begin
          bank1Q[altIdx] <= altWrData;
        end
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rdDataAQ <= '0;
      rdDataBQ <= '0;
      altRdQ <= '0;
    end else if (clkEn) begin
      rdDataAQ <= gprRead(rdIdxA);
      rdDataBQ <= gprRead(rdIdxB);
      if (altRe && altOk) begin
        altRdQ <= bankSel ? bank0Q[altIdx] : bank1Q[altIdx];
      end
    end
  end

  // ----------------------------------------------------------------
  // status word, saved state, pc
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      statusQ <= `BRF_SW_RESET;
      ssrQ <= '0;
      spcQ <= '0;
      pcQ <= `BRF_PC_RESET;
    end else if (clkEn) begin
      if (excTake) begin
        ssrQ <= statusQ;
        spcQ <= pcQ;
        statusQ <= statusQ | (DW'(1) << `BRF_SW_MODE_BIT)
                   | (DW'(1) << `BRF_SW_BANK_BIT)
                   | (DW'(1) << `BRF_SW_BLOCK_BIT);
      end else if (excReturn) begin
        statusQ <= ssrQ & `BRF_SW_PRIV_MASK;
        pcQ <= spcQ;
      end else begin
        if (ctlWe && ctlOk) begin
          case (ctlSel)
            BRF_CTL_STATUS: statusQ <= swMerge(statusQ, ctlWrData, mode);
            BRF_CTL_SSTATUS: ssrQ <= ctlWrData;
            BRF_CTL_SPC: spcQ <= ctlWrData;
            default: ;
          endcase
        end else if (avSwWr) begin
          statusQ <= swMerge(statusQ, avWriteData, 1'b1);
        end
        if (ctlWe && ctlOk && ctlSel == BRF_CTL_PC) begin
          pcQ <= ctlWrData;
        end else if (pcWe) begin
          pcQ <= pcNext;
        end
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      vbrQ <= `BRF_VBR_RESET;
      gbrQ <= '0;
      machQ <= '0;
      maclQ <= '0;
      linkQ <= '0;
    end else if (clkEn) begin
      if (ctlWe && ctlOk) begin
        case (ctlSel)
          BRF_CTL_GBASE: gbrQ <= ctlWrData;
          BRF_CTL_VBASE: vbrQ <= ctlWrData;
          BRF_CTL_MULTIPLY_ACCUMULATE_HIGH: machQ <= ctlWrData;
          BRF_CTL_MULTIPLY_ACCUMULATE_LOW: maclQ <= ctlWrData;
          BRF_CTL_LINK: linkQ <= ctlWrData;
          default: ;
        endcase
      end else if (avAckQ == 1'b1 && avWrite
                   && avAddress == `BRF_OFS_VBR) begin
        vbrQ <= avWriteData;
      end
    end
  end

  // ----------------------------------------------------------------
  // control reads and faults
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ctlRdQ <= '0;
      faultQ <= 1'b0;
      faultCntQ <= '0;
    end else if (clkEn) begin
      faultQ <= ((ctlRe || ctlWe) && !ctlOk) || ((altRe || altWe) && !altOk);
      if (((ctlRe || ctlWe) && !ctlOk) || ((altRe || altWe) && !altOk)) begin
        faultCntQ <= faultCntQ + 16'h0001;
      end
      if (ctlRe && ctlOk) begin
        case (ctlSel)
          BRF_CTL_STATUS: ctlRdQ <= statusQ;
          BRF_CTL_GBASE: ctlRdQ <= gbrQ;
          BRF_CTL_SSTATUS: ctlRdQ <= ssrQ;
          BRF_CTL_SPC: ctlRdQ <= spcQ;
          BRF_CTL_VBASE: ctlRdQ <= vbrQ;
          BRF_CTL_MULTIPLY_ACCUMULATE_HIGH: ctlRdQ <= machQ;
          BRF_CTL_MULTIPLY_ACCUMULATE_LOW: ctlRdQ <= maclQ;
          BRF_CTL_LINK: ctlRdQ <= linkQ;
          default: ctlRdQ <= pcQ;
        endcase
      end else if (ctlRe) begin
        ctlRdQ <= '0;
      end
    end
  end

  // ----------------------------------------------------------------
  // avalon slave, one wait state
  // ----------------------------------------------------------------
  assign avSwWr = avAckQ && avWrite && avAddress == `BRF_OFS_STATUS;
  assign avAckQ = (avStateQ == BRF_AV_DONE);
  assign avWaitRequest = (avRead || avWrite) && !avAckQ;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      avStateQ <= BRF_AV_IDLE;
      avReadData <= '0;
    end else if (clkEn) begin
      case (avStateQ)
        BRF_AV_IDLE: begin
          if (avRead || avWrite) begin
            avStateQ <= BRF_AV_DONE;
          end
          if (avRead) begin
            if (avAddress == `BRF_OFS_STATUS) begin
              avReadData <= statusQ;
            end else if (avAddress == `BRF_OFS_VBR) begin
              avReadData <= vbrQ;
            end else if (avAddress == `BRF_OFS_PC) begin
              avReadData <= pcQ;
            end else if (avAddress == `BRF_OFS_FAULTS) begin
              avReadData <= {16'h0000, faultCntQ};
            end else begin
              avReadData <= 32'h00000000;
            end
          end
        end
        default: avStateQ <= BRF_AV_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign rdDataA = rdDataAQ;
  assign rdDataB = rdDataBQ;
  assign altRdData = altRdQ;
  assign ctlRdData = ctlRdQ;
  assign accessFault = faultQ;
  assign statusWord = statusQ;
  assign progCounter = pcQ;
  assign privMode = mode;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_excMode;
    @(posedge clk_sys) disable iff (!rst_n)
    clkEn && excTake |=> statusQ[`BRF_SW_MODE_BIT]
      && statusQ[`BRF_SW_BLOCK_BIT] && statusQ[`BRF_SW_BANK_BIT];
  endproperty
  a_excMode: assert property (p_excMode)
    else $error("mode not forced on exception");

  property p_excSave;
    @(posedge clk_sys) disable iff (!rst_n)
    clkEn && excTake |=> ssrQ == $past(statusQ) && spcQ == $past(pcQ);
  endproperty
  a_excSave: assert property (p_excSave)
    else $error("state not saved on exception");

  property p_resetVal;
    @(posedge clk_sys) disable iff (!rst_n)
    $rose(rst_n) |-> statusQ == `BRF_SW_RESET && pcQ == `BRF_PC_RESET;
  endproperty
  a_resetVal: assert property (p_resetVal)
    else $error("wrong reset value");

  property p_userAlt;
    @(posedge clk_sys) disable iff (!rst_n)
    clkEn && (altRe || altWe) && !mode |=> accessFault;
  endproperty
  a_userAlt: assert property (p_userAlt)
    else $error("user mode reached other bank");

  property p_userSw;
    @(posedge clk_sys) disable iff (!rst_n)
    clkEn && !mode && !excTake && !excReturn && !avSwWr
      |=> (statusQ & ~`BRF_SW_USER_MASK) == ($past(statusQ) & ~`BRF_SW_USER_MASK);
  endproperty
  a_userSw: assert property (p_userSw)
    else $error("protected status bit changed in user mode");

  property p_privOnly;
    @(posedge clk_sys) disable iff (!rst_n)
    clkEn && ctlWe && !mode && ctlSel == BRF_CTL_VBASE
      && !(avWrite && avAckQ) |=> accessFault && $stable(vbrQ);
  endproperty
  a_privOnly: assert property (p_privOnly)
    else $error("privileged register written in user mode");

  property p_anyMode;
    @(posedge clk_sys) disable iff (!rst_n)
    clkEn && ctlRe && !ctlWe && !altRe && !altWe && (ctlSel == BRF_CTL_GBASE
      || ctlSel == BRF_CTL_STATUS || ctlSel == BRF_CTL_MULTIPLY_ACCUMULATE_HIGH
      || ctlSel == BRF_CTL_LINK) |=> !accessFault;
  endproperty
  a_anyMode: assert property (p_anyMode)
    else $error("mode-free register refused");

  property p_pcAny;
    @(posedge clk_sys) disable iff (!rst_n)
    clkEn && ctlWe && ctlSel == BRF_CTL_PC && !excTake && !excReturn
      |=> pcQ == $past(ctlWrData);
  endproperty
  a_pcAny: assert property (p_pcAny)
    else $error("pc write lost");

  property p_bank1Wr;
    @(posedge clk_sys) disable iff (!rst_n)
    clkEn && gprWe && !gprWrIdx[3] && useBank1
      |=> bank1Q[3'($past(gprWrIdx))] == $past(gprWrData);
  endproperty
  a_bank1Wr: assert property (p_bank1Wr)
    else $error("bank one write missed");

endmodule

// File: sim/brf_core_seq.sv
// core sequencer model: exception entry, return and pc updates
`timescale 1ns/1ns

module brf_core_seq (
  // clock
  input wire logic clk_sys,
  // exception and pc control
  output logic excTake,
  output logic excReturn,
  output logic pcWe,
  output logic [31:0] pcNext
);
  initial begin
    excTake = 1'b0;
    excReturn = 1'b0;
    pcWe = 1'b0;
    pcNext = 32'h0;
  end

  // ----------------------------------------
  // one-cycle request: 0 take, 1 return, 2 pc
  // ----------------------------------------
  task automatic pulse(input int k, input logic [31:0] v);
    @(posedge clk_sys);
    excTake <= (k == 0);
    excReturn <= (k == 1);
    pcWe <= (k == 2);
    pcNext <= v;
    @(posedge clk_sys);
    excTake <= 1'b0;
    excReturn <= 1'b0;
    pcWe <= 1'b0;
    // released value is not left on the lines
    pcNext <= ~v;
  endtask
endmodule

// File: sim/tb_brf_register_file.sv
// self-checking bench for the banked register file
`timescale 1ns/1ns
`include "brf_defs.svh"

module tb_brf_register_file import brf_pkg::*;;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic clkEn = 1'b1;
  logic [3:0] rdIdxA = 4'h0, rdIdxB = 4'h0, gprWrIdx = 4'h0;
  logic gprWe = 1'b0, altRe = 1'b0, altWe = 1'b0;
  logic ctlRe = 1'b0, ctlWe = 1'b0, avRead = 1'b0, avWrite = 1'b0;
  logic [2:0] altIdx = 3'h0;
  logic [31:0] gprWrData = 32'h0, altWrData = 32'h0;
  logic [31:0] ctlWrData = 32'h0, avWriteData = 32'h0;
  brf_ctl_t ctlSel = BRF_CTL_STATUS;
  logic [7:0] avAddress = 8'h00;
  logic [31:0] rdDataA, rdDataB, altRdData, ctlRdData, pcNext, q;
  logic [31:0] statusWord, progCounter, avReadData;
  logic accessFault, privMode, avWaitRequest, excTake, excReturn, pcWe;
  int badCount = 0;
  int nCompared = 0;

  always #20 clk_sys = ~clk_sys;

  brf_register_file brf_register_file_inst (.clk_sys, .rst_n, .clkEn,
    .rdIdxA, .rdIdxB, .rdDataA, .rdDataB, .gprWe, .gprWrIdx, .gprWrData,
    .altRe, .altWe, .altIdx, .altWrData, .altRdData, .ctlRe, .ctlWe,
    .ctlSel, .ctlWrData, .ctlRdData, .accessFault, .excTake, .excReturn,
    .pcWe, .pcNext, .statusWord, .progCounter, .privMode, .avAddress,
    .avRead, .avWrite, .avWriteData, .avReadData, .avWaitRequest);

  brf_core_seq brf_core_seq_inst (.clk_sys, .excTake, .excReturn, .pcWe,
    .pcNext);

  // ----------------------------------------
  // compare and bus tasks
  // ----------------------------------------
  task automatic chk32(input string nm, input logic [31:0] e, g);
    nCompared++;
    if (g !== e) begin
      badCount++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk1(input string nm, input logic e, g);
    chk32(nm, {31'h0, e}, {31'h0, g});
  endtask

  task automatic gw(input logic [3:0] i, input logic [31:0] d);
    @(posedge clk_sys);
    gprWe <= 1'b1;
    gprWrIdx <= i;
    gprWrData <= d;
    @(posedge clk_sys);
    gprWe <= 1'b0;
  endtask

  task automatic gr(input logic [3:0] i, input logic [31:0] e);
    @(posedge clk_sys);
    rdIdxA <= i;
    rdIdxB <= i;
    @(posedge clk_sys);
    @(negedge clk_sys);
    chk32("rdDataA", e, rdDataA);
    chk32("rdDataB", e, rdDataB);
  endtask

  task automatic alt(input logic we, input logic [2:0] i, logic [31:0] d);
    @(posedge clk_sys);
    altWe <= we;
    altRe <= !we;
    altIdx <= i;
    altWrData <= d;
    @(posedge clk_sys);
    altWe <= 1'b0;
    altRe <= 1'b0;
    altWrData <= ~d;
    @(negedge clk_sys);
  endtask

  task automatic ctl(input logic we, input brf_ctl_t s, logic [31:0] d);
    @(posedge clk_sys);
    ctlWe <= we;
    ctlRe <= !we;
    ctlSel <= s;
    ctlWrData <= d;
    @(posedge clk_sys);
    ctlWe <= 1'b0;
    ctlRe <= 1'b0;
    ctlWrData <= ~d;
    @(negedge clk_sys);
  endtask

  task automatic av(input logic wr, input logic [7:0] a, logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    avAddress <= a;
    avWrite <= wr;
    avRead <= !wr;
    avWriteData <= d;
    do begin
      @(posedge clk_sys);
      n++;
    end while (avWaitRequest !== 1'b0 && n < 50);
    q = avReadData;
    avRead <= 1'b0;
    avWrite <= 1'b0;
    if (n >= 50) begin
      badCount++;
    end
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic s_reset();
    chk32("statusWord", `BRF_SW_RESET, statusWord);
    chk1("privMode", 1'b1, privMode);
    ctl(1'b0, BRF_CTL_VBASE, 32'h0);
    chk1("accessFault", 1'b0, accessFault);
  endtask

  task automatic s_banks();
    for (int i = 0; i < 16; i++) gw(i[3:0], 32'hB1000000 | i);
    for (int i = 0; i < 8; i++) alt(1'b1, i[2:0], 32'hB0000000 | i);
    gr(4'h3, 32'hB1000003);
    gr(4'h9, 32'hB1000009);
    alt(1'b0, 3'h3, 32'h0);
    chk32("altRdData", 32'hB0000003, altRdData);
    ctl(1'b1, BRF_CTL_STATUS, 32'h400000F0);
    gr(4'h3, 32'hB0000003);
    alt(1'b0, 3'h3, 32'h0);
    chk32("altRdData", 32'hB1000003, altRdData);
    ctl(1'b1, BRF_CTL_STATUS, 32'h200000F0);
    chk1("privMode", 1'b0, privMode);
    gr(4'h3, 32'hB0000003);
    gr(4'hF, 32'hB100000F);
    alt(1'b1, 3'h3, 32'hDEAD0000);
    chk1("accessFault", 1'b1, accessFault);
  endtask

  task automatic s_user();
    logic f;
    for (int s = 1; s < 9; s++) begin
      f = (s >= 2 && s <= 4);
      ctl(1'b1, brf_ctl_t'(s), 32'hC0DE0000 | s);
      chk1("accessFault", f, accessFault);
      ctl(1'b0, brf_ctl_t'(s), 32'h0);
      chk32("ctlRdData", f ? 32'h0 : 32'hC0DE0000 | s, ctlRdData);
    end
    ctl(1'b1, BRF_CTL_STATUS, 32'hFFFFFFFF);
    chk32("statusWord", 32'h200003F3, statusWord);
    chk1("privMode", 1'b0, privMode);
  endtask

  task automatic s_exc();
    brf_core_seq_inst.pulse(2, 32'h00001000);
    brf_core_seq_inst.pulse(0, 32'h0);
    @(negedge clk_sys);
    chk32("modeBits", 32'h7, {29'h0, statusWord[30:28]});
    chk1("privMode", 1'b1, privMode);
    ctl(1'b0, BRF_CTL_SSTATUS, 32'h0);
    chk32("savedStatus", 32'h200003F3, ctlRdData);
    ctl(1'b0, BRF_CTL_SPC, 32'h0);
    chk32("savedPc", 32'h00001000, ctlRdData);
    gr(4'h3, 32'hB1000003);
    brf_core_seq_inst.pulse(1, 32'h0);
    @(negedge clk_sys);
    chk32("statusWord", 32'h200003F3, statusWord);
    chk1("privMode", 1'b0, privMode);
    chk32("progCounter", 32'h00001000, progCounter);
  endtask

  task automatic s_av();
    av(1'b0, `BRF_OFS_STATUS, 32'h0);
    chk32("avStatus", 32'h200003F3, q);
    av(1'b1, `BRF_OFS_VBR, 32'h0000ABC0);
    av(1'b1, `BRF_OFS_PC, 32'h12345678);
    av(1'b0, `BRF_OFS_PC, 32'h0);
    chk32("avPc", 32'h00001000, q);
    av(1'b0, 8'h10, 32'h0);
    chk32("avUnmapped", 32'h0, q);
    av(1'b1, `BRF_OFS_STATUS, 32'h400000F0);
    @(negedge clk_sys);
    chk1("privMode", 1'b1, privMode);
    ctl(1'b0, BRF_CTL_VBASE, 32'h0);
    chk32("vectorBase", 32'h0000ABC0, ctlRdData);
    // one alt and six control refusals happened in user mode
    av(1'b0, `BRF_OFS_FAULTS, 32'h0);
    chk32("avFaults", 32'h00000007, q);
  endtask

  // a write while the enable is low must not land
  task automatic s_freeze();
    @(posedge clk_sys);
    clkEn <= 1'b0;
    ctl(1'b1, BRF_CTL_GBASE, 32'h0BAD0000);
    @(posedge clk_sys);
    clkEn <= 1'b1;
    ctl(1'b0, BRF_CTL_GBASE, 32'h0);
    chk32("frozenGbase", 32'hC0DE0001, ctlRdData);
  endtask

  // ----------------------------------------
  // run control
  // ----------------------------------------
  task automatic wrap_up();
    $display("compared %0d mismatched %0d", nCompared, badCount);
    if (badCount == 0 && nCompared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    repeat (20) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(negedge clk_sys);
    s_reset();
    s_banks();
    s_user();
    s_exc();
    s_av();
    s_freeze();
    wrap_up();
  end

  initial begin
    #400000;
    badCount++;
    wrap_up();
  end
endmodule
